// [rtl/ssp_spi_port.sv]
// Purpose: Synchronous serial port in SPI mode with an APB register slave.
// Assumes: Pins come from outside pclk domain and are synchronised here.
// Notes: Serial clock from a far master is sampled, so it must run well below pclk/4.
//
// Decided for this implementation: the APB slave port.
`timescale 1ns/1ps
module ssp_spi_port (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic second_timer_count_tick,
	input wire logic sck_in,
	output logic sck_out,
	output logic sck_oe,
	input wire logic sdi,
	output logic sdo,
	output logic sdo_oe,
	input wire logic ss_n,
	output logic irq
);
	ssp_pkg::ssp_ctrl_t ctrl;
	logic smp;
	logic cke;
	logic full;
	logic cap_full;
	logic [7:0] rx_buf;
	logic [7:0] shift_register;
	logic rx_bit;
	logic [4:0] edge_cnt;
	logic master_run;
	logic [5:0] div_cnt;
	logic [2:0] irq_stat;
	logic [2:0] irq_mask;
	logic [2:0] pin_s1;
	logic [2:0] pin_s2;
	logic sck_prev;

	logic acc, wr, rd;
	logic ctrl_wr, stat_wr, buf_wr, buf_rd, irq_rd, mask_wr;
	logic is_master, is_slave, is_spi, ss_gate, port_on, ss_reset, slave_live;
	logic busy, write_collision_flag_ev, ovf_ev, done_ev, store_ev;
	logic m_tick, lead_ev, trail_ev, s_edge, shift_in;
	logic [5:0] half;
	logic [7:0] new_word;
	logic [31:0] next_rdata;
	logic next_err;

	// Pin synchronisers: [0] sck, [1] sdi, [2] ss_n; the first stage feeds only the second
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			// Clock stages start at the reset idle level so no false edge follows reset
			pin_s1 <= 3'h6;
			pin_s2 <= 3'h6;
			sck_prev <= 1'b0;
		end else if (ce) begin
			pin_s1 <= {ss_n, sdi, sck_in};
			pin_s2 <= pin_s1;
			sck_prev <= pin_s2[0];
		end
	end

	// Bus handshake terms
	assign acc = psel & penable & pready;
	assign wr = acc & pwrite;
	assign rd = acc & ~pwrite;
	assign ctrl_wr = wr && paddr == ssp_pkg::CTRL_OFS;
	assign stat_wr = wr && paddr == ssp_pkg::STAT_OFS;
	assign buf_wr = wr && paddr == ssp_pkg::BUF_OFS;
	assign mask_wr = wr && paddr == ssp_pkg::IRQ_MASK_OFS;
	assign buf_rd = rd && paddr == ssp_pkg::BUF_OFS;
	assign irq_rd = rd && paddr == ssp_pkg::IRQ_STAT_OFS;

	// Mode decode
	assign is_master = ctrl.mode <= ssp_pkg::MODE_MASTER_TMR; // RULE_18
	assign ss_gate = ctrl.mode == ssp_pkg::MODE_SLAVE_SEL; // RULE_18
	assign is_slave = ss_gate | (ctrl.mode == ssp_pkg::MODE_SLAVE_NOSEL); // RULE_18
	assign is_spi = is_master | is_slave;
	assign port_on = ctrl.en & is_spi; // RULE_06
	assign ss_reset = port_on & ss_gate & pin_s2[2]; // RULE_10
	// Select pin matters only to a slave, so a master ignores it
	assign slave_live = port_on & is_slave & ~ss_reset; // RULE_09

	// Master rate select; the timer mode toggles once per timer tick
	always_comb begin
		half = ssp_pkg::HALF_DIV4;
		if (ctrl.mode == ssp_pkg::MODE_MASTER_DIV16) begin
			half = ssp_pkg::HALF_DIV16;
		end else if (ctrl.mode == ssp_pkg::MODE_MASTER_DIV64) begin
			half = ssp_pkg::HALF_DIV64;
		end
	end
	assign m_tick = master_run & ((ctrl.mode == ssp_pkg::MODE_MASTER_TMR) ? second_timer_count_tick :
		(div_cnt == half - 6'h01)); // RULE_03

	// Edge events: leading leaves the idle level, trailing returns to it
	assign s_edge = slave_live & (pin_s2[0] != sck_prev);
	assign lead_ev = (m_tick & (sck_out == ctrl.clock_polarity_bit)) | (s_edge & (sck_prev == ctrl.clock_polarity_bit));
	assign trail_ev = (m_tick & (sck_out != ctrl.clock_polarity_bit)) | (s_edge & (sck_prev != ctrl.clock_polarity_bit));
	assign shift_in = cke ? rx_bit : pin_s2[1]; // RULE_04
	assign new_word = {shift_register[6:0], shift_in};
	assign done_ev = trail_ev && edge_cnt == ssp_pkg::LAST_EDGE;
	assign busy = is_master ? master_run : (edge_cnt != 5'h00);
	assign write_collision_flag_ev = buf_wr & busy; // RULE_12
	assign ovf_ev = done_ev & is_slave & full; // RULE_13 RULE_14
	assign store_ev = done_ev & ~ovf_ev;

	// Control register; hardware sets win over software writes
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl <= ssp_pkg::CTRL_RST;
		end else if (ce) begin
			if (ctrl_wr) begin
				ctrl.en <= pwdata[5];
				ctrl.clock_polarity_bit <= pwdata[4];
				ctrl.mode <= pwdata[3:0];
			end
			ctrl.write_collision_flag <= write_collision_flag_ev | (ctrl_wr ? pwdata[7] : ctrl.write_collision_flag); // RULE_12
			ctrl.ovf <= ovf_ev | (ctrl_wr ? pwdata[6] : ctrl.ovf); // RULE_13
		end
	end

	// Status configuration bits
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			{smp, cke} <= ssp_pkg::STAT_CFG_RST;
		end else if (ce && stat_wr) begin
			smp <= pwdata[ssp_pkg::STAT_SMP_BIT]; // RULE_05
			cke <= pwdata[ssp_pkg::STAT_CKE_BIT]; // RULE_05
		end
	end

	// Master clock divider, cleared whenever the master stands
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_cnt <= 6'h00;
		end else if (ce) begin
			if (!master_run || m_tick) begin
				div_cnt <= 6'h00;
			end else begin
				div_cnt <= div_cnt + 6'h01;
			end
		end
	end

	// Master run flag: a buffer write starts a word, the last edge ends it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			master_run <= 1'b0;
		end else if (ce) begin
			if (!port_on || !is_master) begin
				master_run <= 1'b0; // RULE_07
			end else if (done_ev) begin
				master_run <= 1'b0;
			end else if (buf_wr && !busy) begin
				master_run <= 1'b1;
			end
		end
	end

	// Edge counter; select high in mode 0100 or disable resets it mid-word
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			edge_cnt <= 5'h00;
		end else if (ce) begin
			if (!port_on || ss_reset || done_ev) begin
				edge_cnt <= 5'h00; // RULE_10
			end else if (lead_ev || trail_ev) begin
				edge_cnt <= edge_cnt + 5'h01;
			end
		end
	end

	// Shift path: input is sampled on one clock edge, output changes on the other
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			shift_register <= 8'h00;
			rx_bit <= 1'b0;
			sdo <= 1'b0;
		end else if (ce) begin
			if (buf_wr && !busy) begin
				shift_register <= pwdata[7:0];
				if (cke) begin
					sdo <= pwdata[7];
				end
			end else if (trail_ev) begin
				shift_register <= new_word; // RULE_01
				if (cke) begin
					sdo <= shift_register[6]; // RULE_04
				end
			end else if (lead_ev) begin
				if (cke) begin
					rx_bit <= pin_s2[1]; // RULE_04
				end else begin
					sdo <= shift_register[7]; // RULE_04
				end
			end
		end
	end

	// Receive buffer; on overflow the shifted word is dropped
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_buf <= 8'h00;
			full <= 1'b0;
		end else if (ce) begin
			if (store_ev) begin
				rx_buf <= new_word; // RULE_13
			end
			// Only a buffer read set up while the buffer was full empties it
			full <= store_ev | (full & ~(buf_rd & cap_full));
		end
	end

	// Serial clock pin: idle at the polarity level, driven when enabled, by a master or outside SPI with the polarity bit clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sck_out <= 1'b0;
			sck_oe <= 1'b0;
			sdo_oe <= 1'b0;
		end else if (ce) begin
			if (!master_run) begin
				sck_out <= ctrl.clock_polarity_bit; // RULE_16
			end else if (m_tick) begin
				sck_out <= ~sck_out;
			end
			// Outside SPI, with the enable bit set, a clear polarity bit holds the clock line low
			sck_oe <= ctrl.en & (is_master | (~is_spi & ~ctrl.clock_polarity_bit)); // RULE_02 RULE_17
			sdo_oe <= port_on & (is_master | ~ss_gate | ~pin_s2[2]); // RULE_06 RULE_09
		end
	end

	// Interrupt status: reads clear only the bits they returned, so a new set survives
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_stat <= ssp_pkg::IRQ_RST;
			irq_mask <= ssp_pkg::IRQ_RST;
			irq <= 1'b0;
		end else if (ce) begin
			irq_stat[ssp_pkg::IRQ_DONE_BIT] <= done_ev |
				(irq_stat[ssp_pkg::IRQ_DONE_BIT] & ~(irq_rd & prdata[ssp_pkg::IRQ_DONE_BIT]));
			irq_stat[ssp_pkg::IRQ_WRITE_COLLISION_FLAG_BIT] <= write_collision_flag_ev |
				(irq_stat[ssp_pkg::IRQ_WRITE_COLLISION_FLAG_BIT] & ~(irq_rd & prdata[ssp_pkg::IRQ_WRITE_COLLISION_FLAG_BIT]));
			irq_stat[ssp_pkg::IRQ_OVF_BIT] <= ovf_ev |
				(irq_stat[ssp_pkg::IRQ_OVF_BIT] & ~(irq_rd & prdata[ssp_pkg::IRQ_OVF_BIT]));
			if (mask_wr) begin
				irq_mask <= pwdata[2:0];
			end
			irq <= |(irq_stat & irq_mask);
		end
	end

	// Read data and error for the addressed register
	always_comb begin
		next_rdata = 32'h0000_0000;
		next_err = 1'b0;
		if (paddr == ssp_pkg::CTRL_OFS) begin
			next_rdata[7:0] = ctrl;
		end else if (paddr == ssp_pkg::STAT_OFS) begin
			next_rdata[ssp_pkg::STAT_SMP_BIT] = smp;
			next_rdata[ssp_pkg::STAT_CKE_BIT] = cke;
			next_rdata[ssp_pkg::STAT_FULL_BIT] = full;
		end else if (paddr == ssp_pkg::BUF_OFS) begin
			next_rdata[7:0] = rx_buf;
		end else if (paddr == ssp_pkg::IRQ_STAT_OFS) begin
			next_rdata[2:0] = irq_stat;
		end else if (paddr == ssp_pkg::IRQ_MASK_OFS) begin
			next_rdata[2:0] = irq_mask;
		end else begin
			next_err = 1'b1;
		end
	end

	// APB answer: captured in the setup cycle, ready in the first access cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
			cap_full <= 1'b0;
		end else if (ce) begin
			pready <= psel & ~penable;
			if (psel && !penable) begin
				prdata <= pwrite ? 32'h0000_0000 : next_rdata;
				pslverr <= next_err;
				cap_full <= full;
			end else if (acc) begin
				pslverr <= 1'b0;
			end
		end
	end
endmodule

// [rtl/ssp_pkg.sv]
// Purpose: Shared constants and types for the synchronous serial port (SPI mode).
// Assumes: APB slave with 8-bit byte addresses, 32-bit data, registers in the low byte.
// Notes: Overview of the behaviour is listed below.
// Overview of operation
// RULE_01: Eight bits shift out and in together.
// RULE_02: Master drives clock pin, slave reads it.
// RULE_03: Clock rate choice applies to master only.
// RULE_04: Option picks rising or falling output edge.
// RULE_05: Control low six, status top two configure; here status bit 7 (smp) is stored and read back but configures nothing.
// RULE_06: Enable bit five turns port on.
// RULE_07: Software disables before reconfiguring, then enables.
// RULE_08: Software sets pin directions per role.
// RULE_09: Slave select gates slave transfers only.
// RULE_10: Mode 0100: select high resets port logic.
// RULE_11: Slave with edge select one needs select.
// RULE_12: Write while shifting sets sticky collision flag.
// RULE_13: Word arriving over unread buffer flags overflow.
// RULE_14: Overflow is flagged in slave mode only.
// RULE_15: Software reads buffer after every word.
// RULE_16: Polarity bit sets idle clock level.
// RULE_17: Other modes: polarity bit releases or holds clock.
// RULE_18: Mode field encodes master rates and slave kinds.
package ssp_pkg;
	// Register byte addresses
	localparam logic [7:0] CTRL_OFS = 8'h14;
	localparam logic [7:0] STAT_OFS = 8'h18;
	localparam logic [7:0] BUF_OFS = 8'h1c;
	localparam logic [7:0] IRQ_STAT_OFS = 8'h20;
	localparam logic [7:0] IRQ_MASK_OFS = 8'h24;

	// Reset values
	localparam logic [7:0] CTRL_RST = 8'h00;
	localparam logic [1:0] STAT_CFG_RST = 2'h0;
	localparam logic [2:0] IRQ_RST = 3'h0;

	// Field positions
	localparam int STAT_SMP_BIT = 7;
	localparam int STAT_CKE_BIT = 6;
	localparam int STAT_FULL_BIT = 0;
	localparam int IRQ_DONE_BIT = 0;
	localparam int IRQ_WRITE_COLLISION_FLAG_BIT = 1;
	localparam int IRQ_OVF_BIT = 2;

	// Timing counts: clock half periods in pclk cycles, then the index of the last of 16 edges
	localparam logic [5:0] HALF_DIV4 = 6'h02;
	localparam logic [5:0] HALF_DIV16 = 6'h08;
	localparam logic [5:0] HALF_DIV64 = 6'h20;
	localparam logic [4:0] LAST_EDGE = 5'h0f;

	// Mode field encodings
	typedef enum logic [3:0] {
		MODE_MASTER_DIV4 = 4'b0000,
		MODE_MASTER_DIV16 = 4'b0001,
		MODE_MASTER_DIV64 = 4'b0010,
		MODE_MASTER_TMR = 4'b0011,
		MODE_SLAVE_SEL = 4'b0100,
		MODE_SLAVE_NOSEL = 4'b0101
	} ssp_mode_t;

	// Control register layout
	typedef struct packed {
		logic write_collision_flag;
		logic ovf;
		logic en;
		logic clock_polarity_bit;
		logic [3:0] mode;
	} ssp_ctrl_t;
endpackage

// [testbench/ssp_properties.sv]
// Purpose: Port checks for the serial port.
// Assumes: Zero-wait APB slave as handed over.
// Notes: Bound below; sees top ports only.
`timescale 1ns/1ps
module ssp_chk (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	input wire logic psel,
	input wire logic penable,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic sck_out,
	input wire logic sck_oe,
	input wire logic sdo,
	input wire logic irq
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Bus setup and driven clock edge
	sequence s_setup;
		psel && !penable && ce;
	endsequence
	sequence s_edge;
		ce && sck_oe && $past(sck_oe) && $changed(sck_out);
	endsequence
	property p_answer; s_setup |=> pready; endproperty
	property p_pulse; pready && ce |=> !pready; endproperty
	property p_access; pready |-> psel && penable; endproperty
	property p_err; pslverr |-> pready && prdata == 32'h0; endproperty
	property p_upper; pready |-> prdata[31:8] == 24'h0; endproperty
	property p_hold; ce && !(psel && !penable) |=> $stable(prdata); endproperty
	property p_freeze; !ce |=> $stable({sck_out, sck_oe, sdo, irq}); endproperty
	// Fastest rate still holds each level two cycles
	property p_half; s_edge ##1 ce |-> $stable(sck_out); endproperty
	a_answer: assert property (p_answer) else $error("no ready");
	a_pulse: assert property (p_pulse) else $error("long ready");
	a_access: assert property (p_access) else $error("stray ready");
	a_err: assert property (p_err) else $error("bad error");
	a_upper: assert property (p_upper) else $error("upper bits");
	a_hold: assert property (p_hold) else $error("read data moved");
	a_freeze: assert property (p_freeze) else $error("ran while frozen");
	a_half: assert property (p_half) else $error("short half period");
endmodule
bind ssp_spi_port ssp_chk chk_u (.pclk, .presetn, .ce, .psel, .penable, .prdata, .pready,
	.pslverr, .sck_out, .sck_oe, .sdo, .irq);

// [testbench/ssp_far_slave.sv]
// Purpose: Far SPI slave for master runs.
// Assumes: Clock idles low, sampled on rising edge.
// Notes: A released line shows the inverse of its last bit.
`timescale 1ns/1ps
module ssp_far_slave (
	input wire logic sck,
	input wire logic sel_n,
	input wire logic mosi,
	input wire logic [7:0] tx,
	output logic miso,
	output logic [7:0] rx
);
	logic [7:0] sh;
	initial begin
		miso = 1'b0;
		rx = 8'h00;
	end
	// Load on select, MSB first
	always @(negedge sel_n) begin
		sh = tx;
		miso = tx[7];
	end
	always @(posedge sck) if (!sel_n) rx = {rx[6:0], mosi};
	// Shift on falling edge
	always @(negedge sck) begin
		if (!sel_n) begin
			sh = {sh[6:0], 1'b0};
			miso = sh[7];
		end
	end
	always @(posedge sel_n) miso = ~miso;
endmodule

// [testbench/sync_serial_port_spi_tb.sv]
// Purpose: Self-checking bench for the serial port.
// Assumes: Zero-wait APB; far slave model in master runs.
// Notes: The bench plays the far master in slave runs.
`timescale 1ns/1ps
module sync_serial_port_spi_tb;
	typedef struct packed {
		logic w;
		logic [7:0] a;
		logic [31:0] d;
		logic [31:0] e;
		logic er;
	} ssp_row_t;
	logic pclk = 1'b0, presetn = 1'b0, ce = 1'b1, psel = 1'b0, penable = 1'b0;
	logic pwrite = 1'b0, tick = 1'b0, sck_in = 1'b0, ss_n = 1'b1, sel_n = 1'b1;
	logic slv = 1'b0, xsdi = 1'b0, pready, pslverr, sck_out, sck_oe, sdo, sdo_oe, irq, msdi, err;
	logic [7:0] paddr = 8'h00, got, mrx;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	int num_errors = 0, tests_run = 0;
	ssp_row_t rows[7];
	always #50 pclk = ~pclk;
	// Timer tick every other cycle
	always @(posedge pclk) tick <= ~tick;
	ssp_spi_port dut_u (.pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .second_timer_count_tick(tick), .sck_in, .sck_out, .sck_oe,
		.sdi(slv ? xsdi : msdi), .sdo, .sdo_oe, .ss_n, .irq);
	ssp_far_slave far_u (.sck(sck_out), .sel_n, .mosi(sdo), .tx(8'hc3), .miso(msdi), .rx(mrx));
	task give_verdict;
		$display("errors %0d checks %0d", num_errors, tests_run);
		if (num_errors == 0 && tests_run > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task chk(input logic [31:0] g, input logic [31:0] x);
		tests_run++;
		if (g !== x) begin
			num_errors++;
			$display("ERROR t=%0t got=%h exp=%h", $time, g, x);
		end
	endtask
	// Setup, access held until ready seen, release after the taking edge
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int i;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		i = 0;
		// Ready, data and error are taken at the rising edge that sees ready high
		do begin
			@(posedge pclk);
			i++;
		end while (pready !== 1'b1 && i < 50);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (i >= 50) begin
			num_errors++;
			give_verdict;
		end
	endtask
	// Far master, 800 ns clock driven on rising edges; data settles away from sampling
	task ext(input logic [7:0] b, input int n);
		for (int k = 7; k > 7 - n; k--) begin
			repeat (2) @(posedge pclk);
			xsdi <= b[k];
			repeat (2) @(posedge pclk);
			sck_in <= 1'b1;
			repeat (4) @(posedge pclk);
			got[k] = sdo;
			sck_in <= 1'b0;
		end
		repeat (2) @(posedge pclk);
		xsdi <= ~xsdi;
		repeat (2) @(posedge pclk);
	endtask
	initial begin
		rows[0] = '{1'b0, 8'h14, 32'h0, 32'h0, 1'b0};
		rows[1] = '{1'b0, ssp_pkg::STAT_OFS, 32'h0, 32'h0, 1'b0};
		rows[2] = '{1'b0, ssp_pkg::IRQ_MASK_OFS, 32'h0, 32'h0, 1'b0};
		rows[3] = '{1'b1, 8'h14, 32'hffff_ff11, 32'h0, 1'b0};
		rows[4] = '{1'b0, 8'h14, 32'h0, 32'h11, 1'b0};
		rows[5] = '{1'b0, 8'h30, 32'h0, 32'h0, 1'b1};
		rows[6] = '{1'b1, ssp_pkg::STAT_OFS, 32'hc0, 32'h0, 1'b0};
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		foreach (rows[j]) begin
			apb(rows[j].w, rows[j].a, rows[j].d);
			if (!rows[j].w) chk(rd, rows[j].e);
			chk(err, rows[j].er);
		end
		// Master at /16, collision on a second buffer write
		apb(1'b1, 8'h14, 32'h01);
		apb(1'b1, ssp_pkg::STAT_OFS, 32'h40);
		apb(1'b1, 8'h14, 32'h21);
		apb(1'b1, ssp_pkg::IRQ_MASK_OFS, 32'h1);
		chk(sck_oe, 1'b1);
		sel_n <= 1'b0;
		apb(1'b1, ssp_pkg::BUF_OFS, 32'ha5);
		apb(1'b1, ssp_pkg::BUF_OFS, 32'h3c);
		for (int i = 0; i < 600 && irq !== 1'b1; i++) @(posedge pclk);
		chk(irq, 1'b1);
		chk(mrx, 8'ha5);
		sel_n <= 1'b1;
		apb(1'b0, ssp_pkg::BUF_OFS, 32'h0);
		chk(rd, 32'hc3);
		apb(1'b0, 8'h14, 32'h0);
		chk(rd, 32'ha1);
		apb(1'b0, ssp_pkg::IRQ_STAT_OFS, 32'h0);
		chk(rd, 32'h3);
		repeat (2) @(negedge pclk);
		chk(irq, 1'b0);
		// Timer-paced master word, reconfigured with the port off
		apb(1'b1, 8'h14, 32'h03);
		apb(1'b1, 8'h14, 32'h23);
		sel_n <= 1'b0;
		apb(1'b1, ssp_pkg::BUF_OFS, 32'h5a);
		for (int i = 0; i < 600 && irq !== 1'b1; i++) @(posedge pclk);
		chk(irq, 1'b1);
		chk(mrx, 8'h5a);
		sel_n <= 1'b1;
		apb(1'b0, ssp_pkg::BUF_OFS, 32'h0);
		apb(1'b0, ssp_pkg::IRQ_STAT_OFS, 32'h0);
		chk(rd, 32'h1);
		// Idle level high, then a short freeze
		apb(1'b1, 8'h14, 32'h01);
		apb(1'b1, 8'h14, 32'h31);
		repeat (2) @(negedge pclk);
		chk(sck_out, 1'b1);
		@(posedge pclk);
		ce <= 1'b0;
		repeat (3) @(posedge pclk);
		ce <= 1'b1;
		// Slave with select control, interrupts masked
		apb(1'b1, 8'h14, 32'h11);
		apb(1'b1, ssp_pkg::STAT_OFS, 32'h0);
		apb(1'b1, 8'h14, 32'h04);
		apb(1'b1, 8'h14, 32'h24);
		apb(1'b1, ssp_pkg::IRQ_MASK_OFS, 32'h0);
		slv <= 1'b1;
		apb(1'b1, ssp_pkg::BUF_OFS, 32'h96);
		chk(sdo_oe, 1'b0);
		ss_n <= 1'b0;
		ext(8'h5e, 8);
		chk(got, 8'h96);
		apb(1'b0, ssp_pkg::BUF_OFS, 32'h0);
		chk(rd, 32'h5e);
		ext(8'h11, 8);
		ext(8'h22, 8);
		apb(1'b0, 8'h14, 32'h0);
		chk(rd, 32'h64);
		apb(1'b0, ssp_pkg::BUF_OFS, 32'h0);
		chk(rd, 32'h11);
		ext(8'hf0, 4);
		@(posedge pclk);
		ss_n <= 1'b1;
		repeat (4) @(posedge pclk);
		ss_n <= 1'b0;
		ext(8'h3a, 8);
		apb(1'b0, ssp_pkg::BUF_OFS, 32'h0);
		chk(rd, 32'h3a);
		chk(irq, 1'b0);
		apb(1'b0, ssp_pkg::IRQ_STAT_OFS, 32'h0);
		chk(rd, 32'h5);
		give_verdict;
	end
endmodule
